// [hw/cpc_pkg.sv]
// constants and carriers for the console panel control block
// assumes a single 25 MHz clock and an AXI4-Lite master with 32-bit data
package cpc_pkg;
	// ==========================================================
	// panel geometry
	localparam int NUM_REGS = 7;
	localparam int WORD_W = 16;
	localparam int NUM_SEQ = 4;
	// register slots: mask, program addr, storage addr, exchange,
	// accumulator, extension, stop-match
	localparam int IDX_MASK = 0;
	localparam int IDX_PADDR = 1;
	localparam int IDX_SADDR = 2;
	localparam int IDX_XCHG = 3;
	localparam int IDX_ACCUM = 4;
	localparam int IDX_EXT = 5;
	localparam int IDX_STOPM = 6;
	localparam logic [6:0] SEL_RST = 7'h08;
	localparam logic [15:0] WORD_RST = 16'h0000;
	// ==========================================================
	// button vector layout
	localparam int BTN_SEL_LSB = 0;
	localparam int BTN_BIT_LSB = 7;
	localparam int BTN_CLR = 23;
	localparam int BTN_BOOT = 24;
	localparam int BTN_GO = 25;
	localparam int BTN_STOP = 26;
	localparam int BTN_MCLR = 27;
	localparam int BTN_W = 28;
	// ==========================================================
	// bus map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] DISP_OFS = 8'h08;
	localparam int CTRL_W = 2;
	localparam int CTRL_STEP_BIT = 0;
	localparam int CTRL_COMP_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int STAT_RUN_LSB = 0;
	localparam int STAT_SEQ_LSB = 4;
	localparam int STAT_SEL_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		REF_FETCH = 2'h0,
		REF_INDIRECT = 2'h1,
		REF_INDEX = 2'h2,
		REF_OPERAND = 2'h3
	} cpc_ref_kind_e;
	typedef enum logic [2:0] {
		ST_HALT = 3'h1,
		ST_RUN = 3'h2,
		ST_STOPPING = 3'h4
	} cpc_run_e;
	typedef struct packed {
		logic valid;
		cpc_ref_kind_e kind;
		logic is_read;
		logic [15:0] data;
	} cpc_ref_s;
endpackage

// [hw/cpc_console.sv]
// console panel: register select/entry, lamps, autoload, run control
// assumes buttons are synchronous levels and ref_in pulses once per
// completed storage reference while mem_run is high
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module cpc_console
	import cpc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [6:0] btn_sel,
	input wire logic [15:0] btn_bit,
	input wire logic btn_clear,
	input wire logic btn_boot,
	input wire logic btn_go,
	input wire logic btn_stop,
	input wire logic btn_mclr,
	input wire cpc_ref_s ref_in,
	input wire logic [6:0] load_en,
	input wire logic [15:0] load_data,
	output logic [6:0] sel_lamp,
	output logic [15:0] bit_lamp,
	output logic [3:0] seq_lamp,
	output logic mem_run,
	output logic autoload_pulse,
	output logic mclr_pulse,
	output logic [111:0] regs_flat
);
	// ==========================================================
	// button synchroniser and edge detect
	logic [BTN_W-1:0] s1_reg, s2_reg, s3_reg, press;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= {btn_mclr, btn_stop, btn_go, btn_boot, btn_clear,
				btn_bit, btn_sel};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	assign press = s2_reg & ~s3_reg;
	logic [6:0] p_sel, sel_pick;
	logic [15:0] p_bit;
	logic p_clr, p_boot, p_go, p_stop, p_mclr;
	assign p_sel = press[BTN_SEL_LSB +: NUM_REGS];
	assign p_bit = press[BTN_BIT_LSB +: WORD_W];
	assign p_clr = press[BTN_CLR];
	assign p_boot = press[BTN_BOOT];
	assign p_go = press[BTN_GO];
	assign p_stop = press[BTN_STOP];
	assign p_mclr = press[BTN_MCLR];
	// simultaneous presses: lowest selector wins so one stays selected
	assign sel_pick = p_sel & (~p_sel + 7'h01);
	// ==========================================================
	// selection
	logic [6:0] sel_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sel_reg <= SEL_RST;
		else if (p_sel != '0)
			sel_reg <= sel_pick;
	end
	assign sel_lamp = sel_reg;
	// ==========================================================
	// processor registers
	logic [15:0] regs_reg [NUM_REGS];
	logic [15:0] sel_val;
	logic manual_ok, x_load;
	always_comb begin
		sel_val = '0;
		for (int i = 0; i < NUM_REGS; i++)
			sel_val = sel_val | (regs_reg[i] & {WORD_W{sel_reg[i]}});
	end
	// operand store leaves the exchange register alone
	assign x_load = ref_in.valid &&
		(ref_in.kind != REF_OPERAND || ref_in.is_read);
	assign manual_ok = !p_mclr && load_en == '0 && !x_load;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_reg[i] <= WORD_RST;
		end else if (p_mclr) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				if (i != IDX_STOPM)
					regs_reg[i] <= WORD_RST;
			end
		end else if (load_en != '0) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				if (load_en[i])
					regs_reg[i] <= load_data;
			end
		end else if (x_load) begin
			regs_reg[IDX_XCHG] <= ref_in.data;
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				if (sel_reg[i] && p_clr)
					regs_reg[i] <= p_bit;
				else if (sel_reg[i])
					regs_reg[i] <= regs_reg[i] | p_bit;
			end
		end
	end
	for (genvar g = 0; g < NUM_REGS; g++) begin : g_flat
		assign regs_flat[g*WORD_W +: WORD_W] = regs_reg[g];
	end
	logic [15:0] disp_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			disp_reg <= WORD_RST;
		else
			disp_reg <= sel_val;
	end
	assign bit_lamp = disp_reg;
	// ==========================================================
	// storage-reference lamps
	logic [3:0] seq_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn || p_mclr)
			seq_reg <= '0;
		else if (ref_in.valid)
			seq_reg <= 4'h1 << ref_in.kind;
	end
	assign seq_lamp = seq_reg;
	// ==========================================================
	// run control
	logic [CTRL_W-1:0] ctrl_reg;
	cpc_run_e st_reg;
	logic step_reg, step_mode;
	assign step_mode = ctrl_reg[CTRL_STEP_BIT] && ctrl_reg[CTRL_COMP_BIT];
	always_ff @(posedge aclk) begin
		if (!aresetn || p_mclr) begin
			st_reg <= ST_HALT;
			step_reg <= 1'b0;
		end else begin
			case (st_reg)
				ST_HALT: begin
					if (p_go) begin
						st_reg <= ST_RUN;
						step_reg <= step_mode;
					end
				end
				ST_RUN: begin
					// a second run press is simply not looked at
					if (p_stop)
						st_reg <= ST_STOPPING;
					else if (ref_in.valid && step_reg)
						st_reg <= ST_HALT;
				end
				ST_STOPPING: begin
					if (ref_in.valid)
						st_reg <= ST_HALT;
				end
				default: st_reg <= ST_HALT;
			endcase
		end
	end
	assign mem_run = st_reg != ST_HALT;
	logic boot_reg, mclr_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_reg <= 1'b0;
			mclr_reg <= 1'b0;
		end else begin
			boot_reg <= p_boot;
			mclr_reg <= p_mclr;
		end
	end
	assign autoload_pulse = boot_reg;
	assign mclr_pulse = mclr_reg;
	// ==========================================================
	// AXI4-Lite slave
	logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end else if (aw_hold_reg && w_hold_reg) begin
				aw_hold_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (aw_hold_reg && w_hold_reg) begin
				w_hold_reg <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			ctrl_reg <= CTRL_RST;
		end else if (aw_hold_reg && w_hold_reg) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= RESP_OKAY;
			if (awaddr_reg == CTRL_OFS && wstrb_reg[0])
				ctrl_reg <= wdata_reg[CTRL_W-1:0];
			else if (awaddr_reg != STAT_OFS && awaddr_reg != DISP_OFS &&
				awaddr_reg != CTRL_OFS)
				bresp_reg <= RESP_DECERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= '0;
			case (s_axi_araddr)
				CTRL_OFS: rdata_reg[CTRL_W-1:0] <= ctrl_reg;
				STAT_OFS: begin
					rdata_reg[STAT_RUN_LSB +: 3] <= st_reg;
					rdata_reg[STAT_SEQ_LSB +: NUM_SEQ] <= seq_reg;
					rdata_reg[STAT_SEL_LSB +: NUM_REGS] <= sel_reg;
				end
				DISP_OFS: rdata_reg[WORD_W-1:0] <= disp_reg;
				default: rresp_reg <= RESP_DECERR;
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_stop_req;
		st_reg == ST_RUN && p_stop && !p_mclr;
	endsequence
	sequence s_stop_done;
		st_reg == ST_STOPPING && ref_in.valid && !p_mclr;
	endsequence
	chk_sel_onehot: assert property ($onehot(sel_reg))
		else $error("selection not one-hot");
	chk_sel_follow: assert property (p_sel != '0 |=>
		sel_reg == $past(sel_pick))
		else $error("selector press not taken");
	chk_lamp_track: assert property (##1 bit_lamp == $past(sel_val))
		else $error("bit lamps lag the selected register");
	chk_bit_set: assert property (manual_ok && p_bit != '0 &&
		p_sel == '0 |=> (sel_val & $past(p_bit)) == $past(p_bit))
		else $error("bit button did not set bit");
	chk_clear_zero: assert property (manual_ok && p_clr && p_bit == '0 &&
		p_sel == '0 |=> sel_val == '0)
		else $error("clear did not zero register");
	chk_boot_pulse: assert property (p_boot |=> autoload_pulse ##1
		!autoload_pulse)
		else $error("autoload pulse wrong");
	chk_seq_onehot: assert property ($onehot0(seq_reg))
		else $error("two reference lamps lit");
	chk_x_load: assert property (x_load && !p_mclr && load_en == '0 |=>
		regs_reg[IDX_XCHG] == $past(ref_in.data))
		else $error("exchange not loaded by reference");
	chk_go_start: assert property (st_reg == ST_HALT && p_go && !p_mclr |=>
		st_reg == ST_RUN)
		else $error("run press did not start");
	chk_run_hold: assert property (st_reg == ST_RUN && !p_stop &&
		!ref_in.valid && !p_mclr |=> st_reg == ST_RUN)
		else $error("run left without cause");
	chk_stop_seq: assert property (s_stop_req |=> st_reg == ST_STOPPING)
		else $error("stop press not taken");
	chk_stop_halt: assert property (s_stop_done |=> !mem_run)
		else $error("stop did not halt at reference");
	chk_halt_stay: assert property (st_reg == ST_HALT && !p_go |=>
		st_reg == ST_HALT)
		else $error("restart without run press");
	chk_mclr_keep: assert property (p_mclr |=> regs_reg[IDX_STOPM] ==
		$past(regs_reg[IDX_STOPM]) && regs_reg[IDX_PADDR] == '0)
		else $error("master clear wrong");
	chk_step_one: assert property (st_reg == ST_RUN && step_reg &&
		ref_in.valid && !p_stop && !p_mclr |=> st_reg == ST_HALT)
		else $error("cycle step did not halt");
	chk_press_once: assert property (press != '0 |=>
		(press & $past(press)) == '0)
		else $error("held button pulsed twice");
endmodule

// [dv/cpc_ref_model.sv]
// memory sequencer stand-in: completed storage references while running
// assumes mem_run from the console gates the memory cycles
`timescale 1ns/1ns
module cpc_ref_model
	import cpc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic mem_run,
	output cpc_ref_s ref_out
);
	// ======
	// reference generator
	logic [1:0] ph_reg;
	logic [2:0] k_reg;
	// one reference per four cycles; kind walks all four, read flag flips
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_reg <= 2'h0;
			k_reg <= 3'h0;
			ref_out <= '0;
		end else begin
			ref_out.valid <= 1'b0;
			// released data lines wander rather than hold
			ref_out.data <= ~ref_out.data;
			if (mem_run) begin
				ph_reg <= ph_reg + 2'h1;
			end
			if (mem_run && ph_reg == 2'h3) begin
				ref_out.valid <= 1'b1;
				ref_out.kind <= cpc_ref_kind_e'(k_reg[1:0]);
				ref_out.is_read <= k_reg[2];
				ref_out.data <= {13'h0A50, k_reg};
				k_reg <= k_reg + 3'h1;
			end
		end
	end
endmodule

// [dv/cpc_console_tb_top.sv]
// self-checking bench for the console panel block
// assumes the reference model drives ref_in; processor loads held idle
`timescale 1ns/1ns
module cpc_console_tb_top
	import cpc_pkg::*;
;
	// ======
	// signals
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb, seq_lamp, exp_seq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [BTN_W-1:0] btn;
	cpc_ref_s ref_in;
	logic [6:0] sel_lamp;
	logic [15:0] bit_lamp, exp_d;
	logic mem_run, autoload_pulse, mclr_pulse, pend, exp_ld;
	logic [111:0] regs_flat;
	int bad_count, total_checks, al_cnt, mc_cnt, ref_cnt;

	cpc_console dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.btn_sel(btn[BTN_SEL_LSB +: 7]), .btn_bit(btn[BTN_BIT_LSB +: 16]),
		.btn_clear(btn[BTN_CLR]), .btn_boot(btn[BTN_BOOT]),
		.btn_go(btn[BTN_GO]), .btn_stop(btn[BTN_STOP]),
		.btn_mclr(btn[BTN_MCLR]), .ref_in, .load_en(7'h00),
		.load_data(16'h0000), .sel_lamp, .bit_lamp, .seq_lamp, .mem_run,
		.autoload_pulse, .mclr_pulse, .regs_flat);
	cpc_ref_model partner (.aclk, .aresetn, .mem_run, .ref_out(ref_in));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ======
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic hang();
		bad_count++;
		close_out();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit ok;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		ok = 0;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				ok = 1;
			end
		end
		if (!ok) hang();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit ok;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		ok = 0;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				ok = 1;
			end
		end
		if (!ok) hang();
	endtask

	// hold the buttons, release, then let the press settle
	task automatic press(input logic [BTN_W-1:0] m, input int hold);
		@(posedge aclk);
		btn <= m;
		repeat (hold) @(posedge aclk);
		btn <= '0;
		repeat (8) @(posedge aclk);
	endtask

	task automatic wait_halt();
		for (int n = 0; n < 40 && mem_run !== 1'b0; n++) @(posedge aclk);
		if (mem_run !== 1'b0) hang();
	endtask

	// ======
	// reference monitor: lamps and exchange one edge after each reference
	always @(posedge aclk) begin
		if (ref_in.valid === 1'b1) begin
			pend = 1'b1;
			ref_cnt++;
			exp_seq = 4'h1 << ref_in.kind;
			exp_ld = !(ref_in.kind == REF_OPERAND && !ref_in.is_read);
			if (exp_ld) exp_d = ref_in.data;
		end
	end
	always @(negedge aclk) begin
		if (autoload_pulse === 1'b1) al_cnt++;
		if (mclr_pulse === 1'b1) mc_cnt++;
		if (pend) begin
			pend = 1'b0;
			chk("seq_lamp", {28'h0, seq_lamp}, {28'h0, exp_seq});
			chk("xchg", {16'h0, regs_flat[63:48]}, {16'h0, exp_d});
		end
	end

	// ======
	// main sequence
	initial begin
		{bad_count, total_checks, al_cnt, mc_cnt, ref_cnt} = '0;
		pend = 1'b0;
		exp_d = '0;
		btn = '0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk("sel_rst", {25'h0, sel_lamp}, {25'h0, SEL_RST});
		rd(STAT_OFS, rd_d, rsp);
		chk("stat_rst", rd_d, 32'h00000801);
		rd(8'h10, rd_d, rsp);
		chk("bad_rsp", {30'h0, rsp}, {30'h0, RESP_DECERR});
		$display("test reset done");
		for (int i = 0; i < NUM_REGS; i++) begin
			press(28'h1 << (BTN_SEL_LSB + i), 2);
			chk("sel", {25'h0, sel_lamp}, 32'h1 << i);
		end
		press(28'h1 << BTN_CLR, 2);
		press(28'h1234 << BTN_BIT_LSB, 2);
		press(28'h0001 << BTN_BIT_LSB, 2);
		chk("lamps", {16'h0, bit_lamp}, 32'h1235);
		chk("slot6", {16'h0, regs_flat[111:96]}, 32'h1235);
		press(28'h1 << (BTN_SEL_LSB + 1), 2);
		press((28'h1 << BTN_CLR) | (28'h00F0 << BTN_BIT_LSB), 2);
		chk("slot1", {16'h0, regs_flat[31:16]}, 32'h00F0);
		rd(DISP_OFS, rd_d, rsp);
		chk("disp", rd_d, 32'h00F0);
		press(28'h24 << BTN_SEL_LSB, 2);
		chk("sel_two", {25'h0, sel_lamp}, 32'h04);
		press(28'h1 << BTN_BOOT, 10);
		chk("boot", al_cnt, 1);
		$display("test panel entry done");
		wr(CTRL_OFS, 32'h0, rsp);
		chk("wr_ok", {30'h0, rsp}, {30'h0, RESP_OKAY});
		press(28'h1 << BTN_GO, 2);
		chk("go", {31'h0, mem_run}, 32'h1);
		repeat (40) @(posedge aclk);
		press(28'h1 << BTN_GO, 2);
		chk("go_run", {31'h0, mem_run}, 32'h1);
		press(28'h1 << BTN_STOP, 2);
		wait_halt();
		chk("stop", {31'h0, mem_run}, 32'h0);
		press((28'h1 << BTN_BOOT) | (28'h1 << BTN_CLR), 2);
		chk("no_rst", {31'h0, mem_run}, 32'h0);
		chk("boot2", al_cnt, 2);
		$display("test run control done");
		wr(CTRL_OFS, 32'h3, rsp);
		wr(8'h10, 32'h0, rsp);
		chk("bad_wr", {30'h0, rsp}, {30'h0, RESP_DECERR});
		rd(CTRL_OFS, rd_d, rsp);
		chk("ctrl_rb", rd_d, 32'h00000003);
		ref_cnt = 0;
		press(28'h1 << BTN_GO, 2);
		repeat (8) @(posedge aclk);
		wait_halt();
		chk("step", ref_cnt, 1);
		wr(CTRL_OFS, 32'h1, rsp);
		press(28'h1 << BTN_GO, 2);
		repeat (20) @(posedge aclk);
		chk("no_step", {31'h0, mem_run}, 32'h1);
		press(28'h1 << BTN_STOP, 2);
		wait_halt();
		chk("stop2", {31'h0, mem_run}, 32'h0);
		$display("test cycle step done");
		press(28'h1 << BTN_MCLR, 2);
		chk("mclr", mc_cnt, 1);
		chk("keep6", {16'h0, regs_flat[111:96]}, 32'h1235);
		chk("clr1", {16'h0, regs_flat[31:16]}, 32'h0);
		chk("clr_seq", {28'h0, seq_lamp}, 32'h0);
		$display("test master clear done");
		close_out();
	end
endmodule
